/* File: pkg/bsf_pkg.sv */
/*
  Shared constants for the upper-bank register decode and flag register:
  offsets, flag bit positions, reset values and ALU operation codes.
  Assumes an 8-bit data address and an 8-bit data path.
*/
package bsf_pkg;
  // register offsets in the upper bank
  localparam logic [7:0] OFS_INDIRECT_ACCESS_PORT = 8'h80;
  localparam logic [7:0] OFS_TIMER0_PRESCALE      = 8'h81;
  localparam logic [7:0] OFS_PROGRAM_COUNTER_LOW  = 8'h82;
  localparam logic [7:0] OFS_FLAGS                = 8'h83;
  localparam logic [7:0] OFS_INDIRECT_POINTER     = 8'h84;
  localparam logic [7:0] OFS_PORT_A_DIRECTION     = 8'h85;
  localparam logic [7:0] OFS_PORT_B_DIRECTION     = 8'h86;
  localparam logic [7:0] OFS_PORT_C_DIRECTION     = 8'h87;
  localparam logic [7:0] OFS_PC_HIGH_LATCH        = 8'h8a;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL    = 8'h8b;
  localparam logic [7:0] OFS_PERIPH_IRQ_ENABLE    = 8'h8c;
  localparam logic [7:0] OFS_POWER_RESET_CAUSE    = 8'h8e;
  localparam logic [7:0] OFS_TIMER2_PERIOD        = 8'h92;
  localparam logic [7:0] OFS_SERIAL_SLAVE_ADDR    = 8'h93;
  localparam logic [7:0] OFS_SERIAL_PORT_STATE    = 8'h94;
  localparam logic [7:0] OFS_ANALOG_PIN_CONFIG    = 8'h9f;

  // flag register bit positions
  localparam int BIT_INDIRECT_BANK  = 7;
  localparam int BIT_BANK_HIGH      = 6;
  localparam int BIT_BANK_LOW       = 5;
  localparam int BIT_WDOG_EXPIRY_N  = 4;
  localparam int BIT_SLEEP_ENTRY_N  = 3;
  localparam int BIT_ZERO           = 2;
  localparam int BIT_NIBBLE_CARRY   = 1;
  localparam int BIT_CARRY          = 0;

  // implemented-bit masks
  localparam logic [7:0] MASK_PORT_A_DIRECTION = 8'h3f;
  localparam logic [7:0] MASK_PC_HIGH_LATCH    = 8'h1f;
  localparam logic [7:0] MASK_PERIPH_IRQ       = 8'h4f;
  localparam logic [7:0] MASK_POWER_CAUSE      = 8'h03;
  localparam logic [7:0] MASK_ANALOG_PIN       = 8'h07;

  // reset values
  localparam logic [7:0] RST_ZERO              = 8'h00;
  localparam logic [7:0] RST_ONES              = 8'hff;
  localparam logic [7:0] RST_PORT_A_DIRECTION  = 8'h3f;
  localparam logic [7:0] RST_FLAGS_POWER       = 8'h18;
  localparam logic [7:0] RST_POWER_CAUSE       = 8'h03;

  // ALU operations; every code but BSF_OP_NONE touches the condition flags
  typedef enum logic [2:0] {
    BSF_OP_NONE,
    BSF_OP_LOGIC,
    BSF_OP_ADD,
    BSF_OP_SUB,
    BSF_OP_ROT_RIGHT,
    BSF_OP_ROT_LEFT
  } bsf_alu_op_t;

  // reset kinds delivered by the core
  typedef enum logic [1:0] {
    BSF_RST_NONE,
    BSF_RST_POWER,
    BSF_RST_OTHER
  } bsf_rst_kind_t;
endpackage

/* File: rtl/bsf_alu.sv */
/*
  Flag-producing ALU: add, subtract, logic pass-through and rotates.
  Purely combinational; assumes operands are stable for the cycle.
*/
`timescale 1ns/1ps
module bsf_alu (
  // operation
  input  wire bsf_pkg::bsf_alu_op_t op,
  input  wire logic [7:0]           opnd_a,
  input  wire logic [7:0]           opnd_b,
  input  wire logic                 carry_in,
  // result
  output logic       [7:0]          result,
  output logic                      zero,
  output logic                      nibble_carry,
  output logic                      carry
);
  import bsf_pkg::*;

  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] b_eff;
  logic       c_eff;

  always_comb begin
    // subtract adds the two's complement of b
    b_eff        = (op == BSF_OP_SUB) ? ~opnd_b : opnd_b; // R17
    c_eff        = (op == BSF_OP_SUB);
    sum9         = {1'b0, opnd_a} + {1'b0, b_eff} + {8'h00, c_eff};
    sum5         = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
    result       = opnd_a;
    nibble_carry = 1'b0;
    carry        = 1'b0;
    unique case (op)
      BSF_OP_ADD, BSF_OP_SUB: begin
        result       = sum9[7:0];
        nibble_carry = sum5[4]; // R15
        carry        = sum9[8]; // R16
      end
      BSF_OP_ROT_RIGHT: begin
        result = {carry_in, opnd_a[7:1]};
        carry  = opnd_a[0]; // R18
      end
      BSF_OP_ROT_LEFT: begin
        result = {opnd_a[6:0], carry_in};
        carry  = opnd_a[7]; // R18
      end
      BSF_OP_LOGIC, BSF_OP_NONE: begin
        result = opnd_a;
      end
    endcase
    zero = (result == 8'h00); // R14
  end
endmodule

/* File: rtl/bsf_decode.sv */
/*
  Data address former: banked direct or indirect pointer, shared-register fold.
  Assumes the core flags indirect accesses through the access-port location.
*/
`timescale 1ns/1ps
module bsf_decode (
  // addressing
  input  wire logic [6:0] reg_field,
  input  wire logic       indirect,
  input  wire logic       bank_select_low,
  input  wire logic [7:0] pointer,
  // decoded
  output logic      [7:0] data_addr,
  output logic      [7:0] upper_addr,
  output logic            upper_hit
);
  // shared registers answer in either bank
  function automatic logic is_shared(input logic [6:0] a);
    is_shared = (a == 7'h00) || (a == 7'h02) || (a == 7'h03) || (a == 7'h04) ||
                (a == 7'h0a) || (a == 7'h0b); // R1
  endfunction

  always_comb begin
    data_addr  = indirect ? pointer : {bank_select_low, reg_field}; // R20
    upper_hit  = data_addr[7] || is_shared(data_addr[6:0]); // R1
    upper_addr = {1'b1, data_addr[6:0]};
  end
endmodule

/* File: rtl/bsf_regs.sv */
/*
  Upper-bank special register file with the flag register.
  // Function
  // [R1] shared registers decode the same in either bank
  // [R2] upper counter bits reached only through a 5-bit latch, copied on load
  // [R3] unimplemented addresses and bits read zero, writes ignored
  // [R4] every reset loads all port direction registers with ones
  // [R5] power/brown-out and other resets have separate values
  // [R6] flag register accepts any instruction as destination
  // [R7] flag-affecting writes leave zero, nibble and carry to the ALU
  // [R8] expiry and sleep flags are read-only to instructions
  // [R9] software alters flags only with bit, swap or move instructions
  // [R10] software keeps reserved bank bits zero; still writable
  // [R11] bank select low picks lower or upper 128-byte bank
  // [R12] expiry flag set by power-up, kick, sleep; cleared on time-out
  // [R13] sleep flag set by power-up or kick; cleared by sleep
  // [R14] zero flag tracks whether the ALU result is zero
  // [R15] nibble carry is carry out of bit 3 on add and subtract
  // [R16] carry is carry out of bit 7 on add and subtract
  // [R17] subtract adds two's complement; carries mean no borrow
  // [R18] rotates load carry with the bit shifted out
  // [R19] software keeps converter bits zero on parts without converter
  // [R20] direct address is bank select low prefixed to 7-bit field
  Assumes the core presents one access per enabled cycle, with a write
  strobe and, for flag-affecting instructions, the ALU operation and operands.
  rst_n low always loads the power-reset values; a reset kind comes only as a synchronous request.
*/
`timescale 1ns/1ps
module bsf_regs (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire bsf_pkg::bsf_rst_kind_t sync_reset,
  // core access
  input  wire logic [6:0]             reg_field,
  input  wire logic                   indirect,
  input  wire logic                   wr_en,
  input  wire logic [7:0]             wr_data,
  // alu request
  input  wire bsf_pkg::bsf_alu_op_t   alu_op,
  input  wire logic [7:0]             alu_a,
  input  wire logic [7:0]             alu_b,
  // special events
  input  wire logic                   watchdog_kick_instr,
  input  wire logic                   sleep_instr,
  input  wire logic                   watchdog_timeout,
  input  wire logic                   pc_load,
  input  wire logic                   power_cause_in_por,
  input  wire logic                   power_cause_in_bor,
  // outputs
  output logic      [7:0]             rd_data,
  output logic                        rd_hit,
  output logic      [7:0]             data_addr,
  output logic      [7:0]             alu_result,
  output logic      [7:0]             flags,
  output logic      [12:0]            program_counter,
  output logic      [7:0]             indirect_pointer,
  output logic      [7:0]             timer0_prescale_options,
  output logic      [7:0]             port_a_direction,
  output logic      [7:0]             port_b_direction,
  output logic      [7:0]             port_c_direction,
  output logic      [7:0]             interrupt_control,
  output logic      [7:0]             peripheral_irq_enable,
  output logic      [7:0]             timer2_period,
  output logic      [7:0]             serial_port_slave_address,
  output logic      [7:0]             serial_port_state,
  output logic      [7:0]             analog_pin_config
);
  import bsf_pkg::*;

  logic [7:0] flags_q;
  logic [7:0] pc_low_q;
  logic [4:0] pc_high_q;
  logic [7:0] program_counter_high_latch_q;
  logic [7:0] pointer_q;
  logic [7:0] option_q;
  logic [7:0] dir_a_q;
  logic [7:0] dir_b_q;
  logic [7:0] dir_c_q;
  logic [7:0] interrupt_control_q;
  logic [7:0] pie_q;
  logic [7:0] power_reset_cause_q;
  logic [7:0] pr2_q;
  logic [7:0] serial_port_slave_address_q;
  logic [7:0] serial_port_state_q;
  logic [7:0] adcon_q;
  logic [7:0] upper_addr;
  logic       upper_hit;
  logic       alu_zero;
  logic       alu_nc;
  logic       alu_c;
  logic       flag_op;
  logic       is_power;
  logic       is_other;

  bsf_decode u_decode (
    .reg_field       (reg_field),
    .indirect        (indirect),
    .bank_select_low (flags_q[BIT_BANK_LOW]), // R11
    .pointer         (pointer_q),
    .data_addr       (data_addr),
    .upper_addr      (upper_addr),
    .upper_hit       (upper_hit)
  );

  bsf_alu u_alu (
    .op           (alu_op),
    .opnd_a       (alu_a),
    .opnd_b       (alu_b),
    .carry_in     (flags_q[BIT_CARRY]),
    .result       (alu_result),
    .zero         (alu_zero),
    .nibble_carry (alu_nc),
    .carry        (alu_c)
  );

  assign flag_op  = (alu_op != BSF_OP_NONE);
  assign is_power = (sync_reset == BSF_RST_POWER);
  assign is_other = (sync_reset == BSF_RST_OTHER);

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_en && upper_hit && (upper_addr == ofs);
  endfunction

  // flag register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= RST_FLAGS_POWER; // R5
    end else if (clk_en) begin
      if (is_power) begin
        flags_q <= RST_FLAGS_POWER; // R5
      end else if (is_other) begin
        // bank bits clear, condition and power flags unchanged
        flags_q[7:5] <= 3'h0; // R5
      end else begin
        if (hit(OFS_FLAGS)) begin
          flags_q[7:5] <= wr_data[7:5]; // R6 R10
          if (!flag_op) begin
            flags_q[2:0] <= wr_data[2:0]; // R6
          end
        end
        if (flag_op) begin
          // alu outcome beats the written data
          flags_q[BIT_ZERO] <= alu_zero; // R7 R14
          if (alu_op == BSF_OP_ADD || alu_op == BSF_OP_SUB) begin
            flags_q[BIT_NIBBLE_CARRY] <= alu_nc; // R7 R15 R17
          end
          if (alu_op != BSF_OP_LOGIC) begin
            flags_q[BIT_CARRY] <= alu_c; // R7 R16 R18
          end
        end
        // time-out takes priority over the instruction sets
        if (watchdog_timeout) begin
          flags_q[BIT_WDOG_EXPIRY_N] <= 1'b0; // R12 R8
        end else if (watchdog_kick_instr || sleep_instr) begin
          flags_q[BIT_WDOG_EXPIRY_N] <= 1'b1; // R12
        end
        if (sleep_instr) begin
          flags_q[BIT_SLEEP_ENTRY_N] <= 1'b0; // R13 R8
        end else if (watchdog_kick_instr) begin
          flags_q[BIT_SLEEP_ENTRY_N] <= 1'b1; // R13
        end
      end
    end
  end

  // program counter and its high latch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_low_q  <= RST_ZERO;
      pc_high_q <= 5'h00;
      program_counter_high_latch_q  <= RST_ZERO;
    end else if (clk_en) begin
      if (is_power || is_other) begin
        pc_low_q  <= RST_ZERO;
        pc_high_q <= 5'h00;
        program_counter_high_latch_q  <= RST_ZERO;
      end else begin
        if (hit(OFS_PC_HIGH_LATCH)) begin
          program_counter_high_latch_q <= wr_data & MASK_PC_HIGH_LATCH; // R2 R3
        end
        if (hit(OFS_PROGRAM_COUNTER_LOW) || pc_load) begin
          pc_low_q  <= hit(OFS_PROGRAM_COUNTER_LOW) ? wr_data : pc_low_q;
          pc_high_q <= program_counter_high_latch_q[4:0]; // R2
        end
      end
    end
  end

  // port directions: all inputs on any reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir_a_q <= RST_PORT_A_DIRECTION; // R4
      dir_b_q <= RST_ONES;
      dir_c_q <= RST_ONES;
    end else if (clk_en) begin
      if (is_power || is_other) begin
        dir_a_q <= RST_PORT_A_DIRECTION; // R4
        dir_b_q <= RST_ONES; // R4
        dir_c_q <= RST_ONES; // R4
      end else begin
        if (hit(OFS_PORT_A_DIRECTION)) begin
          dir_a_q <= wr_data & MASK_PORT_A_DIRECTION; // R3
        end
        if (hit(OFS_PORT_B_DIRECTION)) begin
          dir_b_q <= wr_data;
        end
        if (hit(OFS_PORT_C_DIRECTION)) begin
          dir_c_q <= wr_data;
        end
      end
    end
  end

  // remaining control registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pointer_q <= RST_ZERO;
      option_q  <= RST_ONES;
      interrupt_control_q  <= RST_ZERO;
      pie_q     <= RST_ZERO;
      pr2_q     <= RST_ONES;
      serial_port_slave_address_q  <= RST_ZERO;
      serial_port_state_q <= RST_ZERO;
      adcon_q   <= RST_ZERO;
    end else if (clk_en) begin
      if (is_power || is_other) begin
        // pointer and interrupt flag bit 0 keep their value on other resets
        if (is_power) begin
          pointer_q <= RST_ZERO; // R5
        end
        interrupt_control_q  <= is_power ? RST_ZERO : {7'h00, interrupt_control_q[0]}; // R5
        option_q  <= RST_ONES;
        pie_q     <= RST_ZERO;
        pr2_q     <= RST_ONES;
        serial_port_slave_address_q  <= RST_ZERO;
        serial_port_state_q <= RST_ZERO;
        adcon_q   <= RST_ZERO;
      end else begin
        if (hit(OFS_INDIRECT_POINTER)) begin
          pointer_q <= wr_data;
        end
        if (hit(OFS_TIMER0_PRESCALE)) begin
          option_q <= wr_data;
        end
        if (hit(OFS_INTERRUPT_CONTROL)) begin
          interrupt_control_q <= wr_data;
        end
        if (hit(OFS_PERIPH_IRQ_ENABLE)) begin
          pie_q <= wr_data & MASK_PERIPH_IRQ; // R3
        end
        if (hit(OFS_TIMER2_PERIOD)) begin
          pr2_q <= wr_data;
        end
        if (hit(OFS_SERIAL_SLAVE_ADDR)) begin
          serial_port_slave_address_q <= wr_data;
        end
        if (hit(OFS_SERIAL_PORT_STATE)) begin
          // only the two sampling-control bits are writable
          serial_port_state_q <= {wr_data[7:6], serial_port_state_q[5:0]};
        end
        if (hit(OFS_ANALOG_PIN_CONFIG)) begin
          adcon_q <= wr_data & MASK_ANALOG_PIN; // R3
        end
      end
    end
  end

  // reset-cause flags: captured from the supervisor on a synchronous power reset; rst_n loads RST_POWER_CAUSE
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_reset_cause_q <= RST_POWER_CAUSE;
    end else if (clk_en) begin
      if (is_power) begin
        power_reset_cause_q <= {6'h00, power_cause_in_por, power_cause_in_bor}; // R5
      end else if (!is_other && hit(OFS_POWER_RESET_CAUSE)) begin
        power_reset_cause_q <= wr_data & MASK_POWER_CAUSE; // R3
      end
    end
  end

  // read mux: unmapped addresses read zero
  always_comb begin
    rd_data = 8'h00; // R3
    rd_hit  = 1'b0;
    if (upper_hit) begin
      rd_hit = 1'b1;
      unique case (upper_addr)
        OFS_INDIRECT_ACCESS_PORT: rd_data = 8'h00;
        OFS_TIMER0_PRESCALE:      rd_data = option_q;
        OFS_PROGRAM_COUNTER_LOW:  rd_data = pc_low_q;
        OFS_FLAGS:                rd_data = flags_q;
        OFS_INDIRECT_POINTER:     rd_data = pointer_q;
        OFS_PORT_A_DIRECTION:     rd_data = dir_a_q;
        OFS_PORT_B_DIRECTION:     rd_data = dir_b_q;
        OFS_PORT_C_DIRECTION:     rd_data = dir_c_q;
        OFS_PC_HIGH_LATCH:        rd_data = program_counter_high_latch_q;
        OFS_INTERRUPT_CONTROL:    rd_data = interrupt_control_q;
        OFS_PERIPH_IRQ_ENABLE:    rd_data = pie_q;
        OFS_POWER_RESET_CAUSE:    rd_data = power_reset_cause_q;
        OFS_TIMER2_PERIOD:        rd_data = pr2_q;
        OFS_SERIAL_SLAVE_ADDR:    rd_data = serial_port_slave_address_q;
        OFS_SERIAL_PORT_STATE:    rd_data = serial_port_state_q;
        OFS_ANALOG_PIN_CONFIG:    rd_data = adcon_q;
        default: begin
          rd_data = 8'h00; // R3
          rd_hit  = 1'b0;
        end
      endcase
    end
  end

  assign flags                     = flags_q;
  assign program_counter           = {pc_high_q, pc_low_q};
  assign indirect_pointer          = pointer_q;
  assign timer0_prescale_options   = option_q;
  assign port_a_direction          = dir_a_q;
  assign port_b_direction          = dir_b_q;
  assign port_c_direction          = dir_c_q;
  assign interrupt_control         = interrupt_control_q;
  assign peripheral_irq_enable     = pie_q;
  assign timer2_period             = pr2_q;
  assign serial_port_slave_address = serial_port_slave_address_q;
  assign serial_port_state         = serial_port_state_q;
  assign analog_pin_config         = adcon_q;
endmodule

/* File: bench/bsf_regs_monitor.sv */
/*
  Concurrent checks on the flag register and the address decode.
  Assumes it is bound to bsf_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
module bsf_regs_monitor (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   clk_en,
  input wire bsf_pkg::bsf_rst_kind_t sync_reset,
  // access and alu
  input wire logic [6:0]             reg_field,
  input wire logic                   indirect,
  input wire bsf_pkg::bsf_alu_op_t   alu_op,
  input wire logic [7:0]             alu_a,
  input wire logic [7:0]             alu_b,
  // events
  input wire logic                   watchdog_kick_instr,
  input wire logic                   sleep_instr,
  input wire logic                   watchdog_timeout,
  // watched outputs
  input wire logic [7:0]             rd_data,
  input wire logic                   rd_hit,
  input wire logic [7:0]             data_addr,
  input wire logic [7:0]             alu_result,
  input wire logic [7:0]             flags,
  input wire logic [7:0]             indirect_pointer,
  input wire logic [7:0]             port_a_direction,
  input wire logic [7:0]             port_b_direction,
  input wire logic [7:0]             port_c_direction
);
  import bsf_pkg::*;
  logic       quiet, no_ev, res_zero, a_ge_b, nib_ge, rot_out;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] exp_res;
  assign quiet    = clk_en && sync_reset == BSF_RST_NONE;
  assign no_ev    = !watchdog_kick_instr && !sleep_instr && !watchdog_timeout;
  // expected result built from operands and the carry flag, not from alu_result
  assign exp_res  = (alu_op == BSF_OP_ADD) ? sum9[7:0] : (alu_op == BSF_OP_SUB) ? alu_a - alu_b :
                    (alu_op == BSF_OP_ROT_RIGHT) ? {flags[0], alu_a[7:1]} :
                    (alu_op == BSF_OP_ROT_LEFT) ? {alu_a[6:0], flags[0]} : alu_a;
  assign res_zero = exp_res == 8'h00;
  assign a_ge_b   = alu_a >= alu_b;
  assign nib_ge   = alu_a[3:0] >= alu_b[3:0];
  assign rot_out  = (alu_op == BSF_OP_ROT_RIGHT) ? alu_a[0] : alu_a[7];
  assign sum9     = {1'b0, alu_a} + {1'b0, alu_b};
  assign nib5     = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  status_ro_a: assert property (
    quiet && no_ev |=> $stable(flags[4:3])) else $error("expiry or sleep flag changed by access");
  timeout_clr_a: assert property (
    quiet && watchdog_timeout |=> !flags[BIT_WDOG_EXPIRY_N]) else $error("expiry flag not cleared");
  sleep_mark_a: assert property (
    quiet && sleep_instr && !watchdog_timeout |=> flags[4:3] == 2'b10) else $error("sleep entry flags wrong");
  kick_mark_a: assert property (
    quiet && watchdog_kick_instr && !sleep_instr && !watchdog_timeout |=> flags[4:3] == 2'b11) else $error("kick flags wrong");
  add_carry_a: assert property (
    quiet && alu_op == BSF_OP_ADD |=> flags[1:0] == {$past(nib5[4]), $past(sum9[8])}) else $error("add carries wrong");
  sub_borrow_a: assert property (
    quiet && alu_op == BSF_OP_SUB |=> flags[1:0] == {$past(nib_ge), $past(a_ge_b)}) else $error("sub borrows wrong");
  zero_track_a: assert property (
    quiet && alu_op != BSF_OP_NONE |=> flags[BIT_ZERO] == $past(res_zero)) else $error("zero flag wrong");
  rot_carry_a: assert property (
    quiet && (alu_op == BSF_OP_ROT_RIGHT || alu_op == BSF_OP_ROT_LEFT) |=> flags[0] == $past(rot_out))
    else $error("rotate carry wrong");
  dir_inputs_a: assert property (
    clk_en && sync_reset != BSF_RST_NONE |=> {port_a_direction, port_b_direction, port_c_direction} == 24'h3fffff)
    else $error("port directions not inputs after reset");
  addr_form_a: assert property (
    data_addr == (indirect ? indirect_pointer : {flags[BIT_BANK_LOW], reg_field})) else $error("address wrong");
  alu_result_a: assert property (
    alu_result == exp_res) else $error("alu result wrong");
  unmapped_zero_a: assert property (
    !rd_hit |-> rd_data == 8'h00) else $error("unmapped read not zero");
  shared_flags_a: assert property (
    !indirect && reg_field == 7'h03 |-> rd_hit && rd_data == flags) else $error("shared flags decode wrong");
endmodule

bind bsf_regs bsf_regs_monitor u_monitor (.*);

/* File: bench/bsf_core_model.sv */
/*
  Stand-in for the core's execution datapath: one access or event per cyc call.
  Assumes the caller owns clock, resets and clk_en.
*/
`timescale 1ns/1ps
module bsf_core_model (
  // clock
  input  wire logic            clock,
  // access
  output logic [6:0]           reg_field,
  output logic                 indirect,
  output logic                 wr_en,
  output logic [7:0]           wr_data,
  output bsf_pkg::bsf_alu_op_t alu_op,
  output logic [7:0]           alu_a,
  output logic [7:0]           alu_b,
  // events
  output logic                 watchdog_kick_instr,
  output logic                 sleep_instr,
  output logic                 watchdog_timeout,
  output logic                 pc_load
);
  import bsf_pkg::*;
  initial begin
    {reg_field, indirect, wr_en, wr_data, alu_a, alu_b} = '0;
    alu_op = BSF_OP_NONE;
    {watchdog_kick_instr, sleep_instr, watchdog_timeout, pc_load} = 4'h0;
  end
  // strict off only where a scenario breaks software habits on purpose
  task automatic cyc(input logic [6:0] f, input logic ind, input logic wr, input logic [7:0] d,
                     input bsf_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                     input logic [3:0] ev, input logic strict);
    @(posedge clock);
    reg_field <= f;
    indirect  <= ind;
    wr_en     <= wr;
    wr_data   <= !strict ? d : (f == 7'h03) ? (d & 8'h3f) : (f == 7'h1f) ? 8'h00 : d;
    alu_op    <= (strict && wr && f == 7'h03) ? BSF_OP_NONE : op;
    alu_a     <= a;
    alu_b     <= b;
    {watchdog_kick_instr, sleep_instr, watchdog_timeout, pc_load} <= ev;
    @(posedge clock);
    wr_en  <= 1'b0;
    alu_op <= BSF_OP_NONE;
    {watchdog_kick_instr, sleep_instr, watchdog_timeout, pc_load} <= 4'h0;
  endtask
endmodule

/* File: bench/bsf_regs_tb_top.sv */
/*
  Self-checking bench: a table of flag-setting operations, then flag
  write masking, banking, indirect access, the counter latch and resets.
  Assumes bsf_core_model drives the access side; the bench owns resets.
*/
`timescale 1ns/1ps
module bsf_regs_tb_top;
  import bsf_pkg::*;
  typedef struct packed {
    bsf_alu_op_t op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [2:0]  zdc;
  } bsf_row_t;
  logic          clock, rst_n, clk_en, power_cause_in_por, power_cause_in_bor;
  bsf_rst_kind_t sync_reset;
  logic [6:0]    reg_field;
  logic          indirect, wr_en, watchdog_kick_instr, sleep_instr, watchdog_timeout, pc_load, rd_hit;
  logic [7:0]    wr_data, alu_a, alu_b, rd_data, data_addr, alu_result, flags, indirect_pointer;
  logic [7:0]    timer0_prescale_options, port_a_direction, port_b_direction, port_c_direction, timer2_period;
  bsf_alu_op_t   alu_op;
  logic [12:0]   program_counter;
  int            err_total, n_tests;
  bsf_row_t      rows [9] = '{
    '{BSF_OP_ADD, 8'h0f, 8'h01, 3'b010}, '{BSF_OP_ADD, 8'hff, 8'h01, 3'b111},
    '{BSF_OP_ADD, 8'h12, 8'h34, 3'b000}, '{BSF_OP_SUB, 8'h05, 8'h05, 3'b111},
    '{BSF_OP_SUB, 8'h10, 8'h01, 3'b001}, '{BSF_OP_SUB, 8'h01, 8'h02, 3'b000},
    '{BSF_OP_LOGIC, 8'h00, 8'h00, 3'b100}, '{BSF_OP_ROT_RIGHT, 8'h01, 8'h01, 3'b101},
    '{BSF_OP_ROT_LEFT, 8'h80, 8'h80, 3'b001}};

  bsf_core_model core (.*);
  bsf_regs dut (.*, .interrupt_control(), .peripheral_irq_enable(), .serial_port_slave_address(),
                .serial_port_state(), .analog_pin_config());

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] f, input logic [7:0] d, input logic strict = 1'b1);
    core.cyc(f, 1'b0, 1'b1, d, BSF_OP_NONE, 8'h00, 8'h00, 4'h0, strict);
    #1;
  endtask
  task automatic rd(input logic [6:0] f, input logic ind = 1'b0);
    core.cyc(f, ind, 1'b0, 8'h00, BSF_OP_NONE, 8'h00, 8'h00, 4'h0, 1'b1);
    #1;
  endtask
  task automatic ev(input logic [3:0] e);
    core.cyc(7'h20, 1'b0, 1'b0, 8'h00, BSF_OP_NONE, 8'h00, 8'h00, e, 1'b1);
    #1;
  endtask
  task automatic sres(input bsf_rst_kind_t k, input logic [1:0] cause);
    @(posedge clock);
    sync_reset <= k;
    {power_cause_in_por, power_cause_in_bor} <= cause;
    @(posedge clock);
    sync_reset <= BSF_RST_NONE;
    #1;
  endtask

  // hang guard only: every wait below is a fixed count
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    sync_reset = BSF_RST_NONE;
    {power_cause_in_por, power_cause_in_bor} = 2'b00;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      core.cyc(7'h20, 1'b0, 1'b0, 8'h00, rows[i].op, rows[i].a, rows[i].b, 4'h0, 1'b1);
      #1;
      chk("zdc", 24'(flags[2:0]), 24'(rows[i].zdc));
    end
    ev(4'b0100);
    chk("sleep", 24'(flags), 24'h11);
    ev(4'b0010);
    chk("timeout", 24'(flags), 24'h01);
    wr(7'h03, 8'hff, 1'b0);
    chk("flag_wr", 24'(flags), 24'he7);
    ev(4'b1000);
    chk("kick", 24'(flags), 24'hff);
    // clear-style write: condition flags come from the alu, not the data
    core.cyc(7'h03, 1'b0, 1'b1, 8'h00, BSF_OP_ADD, 8'h00, 8'h00, 4'h0, 1'b0);
    #1;
    chk("alu_wr", 24'(flags), 24'h1c);
    rd(7'h03);
    chk("shared0", 24'({rd_hit, data_addr, rd_data}), 24'h1031c);
    wr(7'h03, 8'h24);
    rd(7'h03);
    chk("shared1", 24'({rd_hit, data_addr, rd_data}), 24'h1833c);
    rd(7'h06);
    chk("bank1", 24'({rd_hit, data_addr, rd_data}), 24'h186ff);
    rd(7'h08);
    chk("unmapped", 24'({rd_hit, data_addr, rd_data}), 24'h08800);
    wr(7'h05, 8'hff);
    chk("dir_a_bits", 24'(rd_data), 24'h3f);
    wr(7'h04, 8'h92);
    rd(7'h00, 1'b1);
    chk("indirect", 24'({rd_hit, data_addr, rd_data}), 24'h192ff);
    wr(7'h0a, 8'hff);
    chk("latch_bits", 24'(rd_data), 24'h1f);
    wr(7'h02, 8'h34);
    chk("pc_write", 24'(program_counter), 24'h1f34);
    wr(7'h0a, 8'h05);
    ev(4'b0001);
    chk("pc_load", 24'(program_counter[12:8]), 24'h05);
    wr(7'h06, 8'h00);
    chk("dir_b_wr", 24'(port_b_direction), 24'h00);
    sres(BSF_RST_OTHER, 2'b00);
    chk("other_dir", 24'(port_b_direction), 24'hff);
    chk("other_kept", 24'({flags, indirect_pointer}), 24'h1c92);
    sres(BSF_RST_POWER, 2'b10);
    chk("power", 24'({flags, program_counter}), 24'h30000);
    wr(7'h04, 8'h8e);
    rd(7'h00, 1'b1);
    chk("cause", 24'(rd_data), 24'h02);
    wr(7'h03, 8'h20);
    wr(7'h07, 8'h00);
    wr(7'h01, 8'h00);
    wr(7'h0c, 8'hff);
    chk("pie_bits", 24'(rd_data), 24'h4f);
    wr(7'h14, 8'hff);
    chk("ssp_bits", 24'(rd_data), 24'hc0);
    wr(7'h1f, 8'hff, 1'b0);
    chk("adc_bits", 24'(rd_data), 24'h07);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk("por_dirs", 24'({port_c_direction, timer0_prescale_options, port_a_direction}), 24'hffff3f);
    chk("por_flags", 24'({flags, timer2_period}), 24'h18ff);
    tally_and_finish();
  end
endmodule
